// file: hdl/cfg_if.sv
// interface: link between control logic and configuration store
`timescale 1ns/10ps
`default_nettype none
interface cfg_if;
   import pld_pkg::*;
   logic erase_req;
   logic busy;
   logic wr_en;
   logic [ADDR_W-1:0] wr_addr;
   logic [WORD_BITS-1:0] wr_data;
   logic [CELL_W-1:0] wr_limit;
   logic [ADDR_W-1:0] rd_addr;
   logic [WORD_BITS-1:0] rd_data;
   logic [SIG_CELLS-1:0] user_signature_variant;
   logic [WORD_BITS-1:0] word0;
   modport ctrl (output erase_req, wr_en, wr_addr, wr_data, wr_limit,
      rd_addr, input busy, rd_data, user_signature_variant, word0);
   modport store (input erase_req, wr_en, wr_addr, wr_data, wr_limit,
      rd_addr, output busy, rd_data, user_signature_variant, word0);
endinterface
`default_nettype wire

// file: hdl/cfg_store.sv
// configuration cell store with built-in erase and signature capture
`timescale 1ns/10ps
`default_nettype none
module cfg_store
   import pld_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   cfg_if.store cfg
);
   logic [WORD_BITS-1:0] mem [IMG_WORDS];
   logic [ADDR_W-1:0] erase_cnt;
   logic busy;
   logic [SIG_CELLS-1:0] sig;
   logic [WORD_BITS-1:0] word0;
   logic [WORD_BITS-1:0] rd_data;
   logic [WORD_BITS-1:0] wmask;
   logic [WORD_BITS-1:0] next_word;

   assign cfg.busy = busy;
   assign cfg.user_signature_variant = sig;
   assign cfg.word0 = word0;
   assign cfg.rd_data = rd_data;

   // cells past the image length are not written
   always_comb begin
      for (int i = 0; i < WORD_BITS; i++) begin
         wmask[i] = ({cfg.wr_addr, 5'h00} + CELL_W'(i)) < cfg.wr_limit;
      end
      next_word = (mem[cfg.wr_addr] & ~wmask) | (cfg.wr_data & wmask);
   end

   // erase sweeps every word before new data is accepted
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy <= 1'b0;
         erase_cnt <= '0;
      end else if (cfg.erase_req) begin
         busy <= 1'b1;
         erase_cnt <= '0;
      end else if (busy) begin
         if (erase_cnt == ADDR_W'(IMG_WORDS - 1)) begin
            busy <= 1'b0;
         end
         erase_cnt <= erase_cnt + 8'h01;
      end
   end

   always_ff @(posedge clk_i) begin
      if (busy) begin
         mem[erase_cnt] <= '0;
      end else if (cfg.wr_en) begin
         mem[cfg.wr_addr] <= next_word;
      end
   end

   always_ff @(posedge clk_i) begin
      rd_data <= mem[cfg.rd_addr];
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || cfg.erase_req) begin
         word0 <= '0;
      end else if (cfg.wr_en && !busy && cfg.wr_addr == 8'h00) begin
         word0 <= next_word;
      end
   end

   // signature cells gathered from the stream; a short image leaves them
   // erased
   always_ff @(posedge clk_i) begin
      if (rst_i || cfg.erase_req) begin
         sig <= '0;
      end else if (cfg.wr_en && !busy) begin
         for (int i = 0; i < WORD_BITS; i++) begin
            if (wmask[i] &&
               ({cfg.wr_addr, 5'h00} + CELL_W'(i)) >= CELL_W'(SIG_BASE)) begin
               sig[6'({cfg.wr_addr, 5'h00} + CELL_W'(i)
                  - CELL_W'(SIG_BASE))] <= cfg.wr_data[i];
            end
         end
      end
   end
endmodule
`default_nettype wire

// file: hdl/pld_pkg.sv
// package: constants for the configuration guard and macrocell control
package pld_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int POR_TIME_NS = 1000;
   // longest time: rounds down, never below one cycle
   localparam int POR_CYCLES = (POR_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 :
      (POR_TIME_NS / CLK_PERIOD_NS);
   localparam int POR_W = 8;

   localparam int CELLS_FULL = 5892;
   localparam int CELLS_STD = 5828;
   localparam int SIG_CELLS = 64;
   localparam int SIG_BASE = CELLS_STD;
   localparam int WORD_BITS = 32;
   localparam int IMG_WORDS = (CELLS_FULL + WORD_BITS - 1) / WORD_BITS;
   localparam int ADDR_W = 8;
   localparam int CELL_W = 13;
   localparam int MC_COUNT = 10;
   localparam int IN_COUNT = 12;
   localparam int PIN_COUNT = IN_COUNT + MC_COUNT;

   // polarity and enable cells live in configuration word 0
   localparam int POL_LSB = 0;
   localparam int OE_LSB = 10;

   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CMD = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_PROG_DATA = 8'h0C;
   localparam logic [7:0] OFS_RD_ADDR = 8'h10;
   localparam logic [7:0] OFS_RD_DATA = 8'h14;
   localparam logic [7:0] OFS_SIG_LO = 8'h18;
   localparam logic [7:0] OFS_SIG_HI = 8'h1C;
   localparam logic [7:0] OFS_PRELOAD = 8'h20;
   localparam logic [7:0] OFS_MC_STATE = 8'h24;
   localparam logic [7:0] OFS_PINS = 8'h28;

   localparam int CTRL_TEST = 0;
   localparam int CTRL_STD = 1;
   localparam int CMD_PROG_START = 0;
   localparam int CMD_PROG_END = 1;
   localparam int CMD_SECURE = 2;
   localparam int CMD_PRELOAD = 3;
   localparam int CMD_STEP = 4;
   localparam int ST_SECURED = 0;
   localparam int ST_BUSY = 1;
   localparam int ST_PROG = 2;
   localparam int ST_POR_DONE = 3;
   localparam int ST_RD_REFUSED = 4;
   localparam int ST_PL_REFUSED = 5;
   localparam int ST_STD = 6;

   localparam logic [1:0] CTRL_RESET = 2'h0;
   localparam logic [MC_COUNT-1:0] PRELOAD_RESET = 10'h000;
   localparam logic [ADDR_W-1:0] RD_ADDR_RESET = 8'h00;
endpackage

// file: hdl/pld_register_init_and_config_guard.sv
// top: config guard, power-up reset, preload and pin conditioning
`timescale 1ns/10ps
`default_nettype none
module pld_register_init_and_config_guard
   import pld_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic mc_clk_i,
   input wire logic [IN_COUNT-1:0] in_pin_i,
   input wire logic [IN_COUNT-1:0] in_float_i,
   input wire logic [MC_COUNT-1:0] io_pin_i,
   input wire logic [MC_COUNT-1:0] io_float_i,
   input wire logic [MC_COUNT-1:0] mc_d_i,
   output logic [MC_COUNT-1:0] io_pin_o,
   output logic [MC_COUNT-1:0] io_pin_oe_n_o,
   output logic [MC_COUNT-1:0] mc_q_o,
   output logic [PIN_COUNT-1:0] pin_level_o
);
   cfg_if cfg ();

   cfg_store u_store (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cfg(cfg)
   );

   logic [1:0] ctrl;
   logic [MC_COUNT-1:0] preload_val;
   logic [ADDR_W-1:0] rd_addr;
   logic secured;
   logic programming;
   logic image_std;
   logic rd_refused;
   logic pl_refused;
   logic [ADDR_W-1:0] wr_ptr;
   logic [POR_W-1:0] por_cnt;
   logic por_done;
   logic [MC_COUNT-1:0] mc_q;
   logic ack;
   logic [31:0] dat;
   logic req;
   logic stall;
   logic wr_req;
   logic rd_req;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic cmd_wr;
   logic prog_start;
   logic prog_end;
   logic secure_cmd;
   logic preload_cmd;
   logic step_cmd;
   logic data_wr;
   logic rd_deny;
   logic pl_deny;
   logic erase_req;
   logic [ADDR_W-1:0] img_words;
   logic [2*PIN_COUNT-1:0] pad_meta;
   logic [2*PIN_COUNT-1:0] pad_sync;
   logic [PIN_COUNT-1:0] pad_lvl;
   logic [PIN_COUNT-1:0] pad_flt;
   logic [PIN_COUNT-1:0] pin_sync;
   logic [PIN_COUNT-1:0] pin_raw;
   logic [1:0] clk_meta;
   logic clk_sync;
   logic clk_prev;
   logic mc_edge;
   logic [MC_COUNT-1:0] polarity;
   logic [MC_COUNT-1:0] oe_cell;

   // wishbone decode: one request, answered in the next cycle unless a data write stalls on busy
   assign req = wb_cyc_i && wb_stb_i && !ack;
   assign stall = wb_we_i && wb_adr_i == OFS_PROG_DATA && cfg.busy;
   assign wr_req = req && wb_we_i && !stall;
   assign rd_req = req && !wb_we_i;
   assign wb_ack_o = ack;
   assign wb_dat_o = dat;

   // byte lanes merged into the write word
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         wdata[8*b +: 8] = wb_sel_i[b] ? wb_dat_i[8*b +: 8] : 8'h00;
      end
   end

   assign cmd_wr = wr_req && wb_adr_i == OFS_CMD;
   assign prog_start = cmd_wr && wdata[CMD_PROG_START];
   assign prog_end = cmd_wr && wdata[CMD_PROG_END] && !prog_start;
   assign secure_cmd = cmd_wr && wdata[CMD_SECURE] && !programming
      && !prog_start;
   assign preload_cmd = cmd_wr && wdata[CMD_PRELOAD];
   assign step_cmd = cmd_wr && wdata[CMD_STEP];
   assign data_wr = wr_req && wb_adr_i == OFS_PROG_DATA && programming
      && wr_ptr < img_words;
   // a secured device refuses array readback
   assign rd_deny = rd_req && wb_adr_i == OFS_RD_DATA && secured;
   // preload outside test mode is refused
   assign pl_deny = preload_cmd && !ctrl[CTRL_TEST];
   assign erase_req = prog_start;

   // standard image holds fewer words and no signature
   assign img_words = image_std
      ? ADDR_W'((CELLS_STD + WORD_BITS - 1) / WORD_BITS)
      : ADDR_W'(IMG_WORDS);

   assign cfg.erase_req = erase_req;
   assign cfg.wr_en = data_wr;
   assign cfg.wr_addr = wr_ptr;
   assign cfg.wr_data = wdata;
   assign cfg.wr_limit = image_std ? CELL_W'(CELLS_STD)
      : CELL_W'(CELLS_FULL);
   assign cfg.rd_addr = rd_addr;

   // ack follows one cycle after a request is taken
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack <= 1'b0;
      end else begin
         ack <= req && !stall;
      end
   end

   always_comb begin
      rdata = 32'h0000_0000;
      case (wb_adr_i)
         OFS_CTRL: rdata[1:0] = ctrl;
         OFS_STATUS: begin
            rdata[ST_SECURED] = secured;
            rdata[ST_BUSY] = cfg.busy;
            rdata[ST_PROG] = programming;
            rdata[ST_POR_DONE] = por_done;
            rdata[ST_RD_REFUSED] = rd_refused;
            rdata[ST_PL_REFUSED] = pl_refused;
            rdata[ST_STD] = image_std;
         end
         OFS_RD_ADDR: rdata[ADDR_W-1:0] = rd_addr;
         OFS_RD_DATA: begin
            // words past the image read as erased cells
            if (!secured && rd_addr < ADDR_W'(IMG_WORDS)) begin
               rdata = cfg.rd_data;
            end
         end
         // signature stays readable whatever the security cell
         OFS_SIG_LO: rdata = cfg.user_signature_variant[31:0];
         OFS_SIG_HI: rdata = cfg.user_signature_variant[63:32];
         OFS_PRELOAD: rdata[MC_COUNT-1:0] = preload_val;
         OFS_MC_STATE: rdata[MC_COUNT-1:0] = mc_q;
         OFS_PINS: rdata[PIN_COUNT-1:0] = pin_sync;
         default: rdata = 32'h0000_0000;
      endcase
   end

   // read data taken at the request edge, held until the next read
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat <= 32'h0000_0000;
      end else if (rd_req) begin
         dat <= rdata;
      end
   end

   // control, preload value and readback address registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= CTRL_RESET;
         preload_val <= PRELOAD_RESET;
         rd_addr <= RD_ADDR_RESET;
      end else if (wr_req) begin
         if (wb_adr_i == OFS_CTRL) begin
            ctrl <= wdata[1:0];
         end
         if (wb_adr_i == OFS_PRELOAD) begin
            preload_val <= wdata[MC_COUNT-1:0];
         end
         if (wb_adr_i == OFS_RD_ADDR) begin
            rd_addr <= wdata[ADDR_W-1:0];
         end
      end
   end

   // programming session: erase first, then stream words
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         programming <= 1'b0;
         image_std <= 1'b0;
         wr_ptr <= '0;
      end else if (prog_start) begin
         programming <= 1'b1;
         image_std <= ctrl[CTRL_STD];
         wr_ptr <= '0;
      end else begin
         if (prog_end) begin
            programming <= 1'b0;
         end
         if (data_wr) begin
            wr_ptr <= wr_ptr + 8'h01;
         end
      end
   end

   // security cell: set by command, cleared by reset or by reprogramming
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         secured <= 1'b0;
      end else if (prog_start) begin
         secured <= 1'b0;
      end else if (secure_cmd) begin
         secured <= 1'b1;
      end
   end

   // sticky refusal flags, write one to clear; a new event wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_refused <= 1'b0;
         pl_refused <= 1'b0;
      end else begin
         if (rd_deny) begin
            rd_refused <= 1'b1;
         end else if (wr_req && wb_adr_i == OFS_STATUS
            && wdata[ST_RD_REFUSED]) begin
            rd_refused <= 1'b0;
         end
         if (pl_deny) begin
            pl_refused <= 1'b1;
         end else if (wr_req && wb_adr_i == OFS_STATUS
            && wdata[ST_PL_REFUSED]) begin
            pl_refused <= 1'b0;
         end
      end
   end

   // power-up reset interval after release
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         por_cnt <= '0;
         por_done <= 1'b0;
      end else if (!por_done) begin
         por_cnt <= por_cnt + 8'h01;
         por_done <= por_cnt == POR_W'(POR_CYCLES - 1);
      end
   end

   // external clock pin, two flops then edge detect
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clk_meta <= 2'h0;
         clk_prev <= 1'b0;
      end else begin
         clk_meta <= {clk_meta[0], mc_clk_i};
         clk_prev <= clk_sync;
      end
   end
   assign clk_sync = clk_meta[1];
   // edges during power-up are ignored
   assign mc_edge = clk_sync && !clk_prev && por_done;

   // macrocell registers: cleared at power-up, preload in test mode only
   always_ff @(posedge clk_i) begin
      if (rst_i || !por_done) begin
         mc_q <= '0;
      end else if (preload_cmd && ctrl[CTRL_TEST]) begin
         mc_q <= preload_val;
      end else if (ctrl[CTRL_TEST] ? step_cmd : mc_edge) begin
         mc_q <= mc_d_i;
      end
   end

   // pin levels and float flags pass two flops before any logic reads them
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pad_meta <= '1;
         pad_sync <= '1;
      end else begin
         pad_meta <= {io_float_i, in_float_i, io_pin_i, in_pin_i};
         pad_sync <= pad_meta;
      end
   end
   assign pad_lvl = pad_sync[PIN_COUNT-1:0];
   assign pad_flt = pad_sync[2*PIN_COUNT-1:PIN_COUNT];

   // pins: a floating input reads high through the pull-up
   generate
      for (genvar p = 0; p < PIN_COUNT; p++) begin : g_pin
         if (p < IN_COUNT) begin : g_in
            assign pin_raw[p] = pad_flt[p] || pad_lvl[p];
         end else begin : g_io
            assign pin_raw[p] = (pad_flt[p]
               && io_pin_oe_n_o[p-IN_COUNT]) || pad_lvl[p];
         end
      end
   endgenerate

   // pin levels registered once more for the pin level output
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_sync <= '1;
      end else begin
         pin_sync <= pin_raw;
      end
   end

   // polarity and enable cells sit in configuration word 0
   assign polarity = cfg.word0[POL_LSB +: MC_COUNT];
   assign oe_cell = cfg.word0[OE_LSB +: MC_COUNT];

   // pins show the register through the programmed polarity
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         io_pin_o <= '0;
         io_pin_oe_n_o <= '1;
      end else begin
         io_pin_o <= mc_q ^ polarity;
         io_pin_oe_n_o <= ~oe_cell;
      end
   end

   assign mc_q_o = mc_q;
   assign pin_level_o = pin_sync;
endmodule
`default_nettype wire

// file: sim/pld_guard_sva.sv
// checker: port assertions for the config guard
`timescale 1ns/10ps
`default_nettype none
module pld_guard_sva
   import pld_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic mc_clk_i,
   input wire logic [IN_COUNT-1:0] in_float_i,
   input wire logic [MC_COUNT-1:0] mc_d_i,
   input wire logic [MC_COUNT-1:0] io_pin_o,
   input wire logic [MC_COUNT-1:0] io_pin_oe_n_o,
   input wire logic [MC_COUNT-1:0] mc_q_o,
   input wire logic [PIN_COUNT-1:0] pin_level_o
);
   logic sec, prog, tst, cmd, wrt, rd;
   logic [MC_COUNT-1:0] pre;
   logic [7:0] por;
   assign wrt = wb_ack_o && wb_we_i;
   assign cmd = wrt && wb_adr_i == OFS_CMD;
   assign rd = wb_ack_o && !wb_we_i;
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         por <= 8'h00;
      end else if (por != 8'hFF) begin
         por <= por + 8'h01;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sec <= 1'b0;
         prog <= 1'b0;
      end else if (cmd) begin
         sec <= !wb_dat_i[CMD_PROG_START] &&
            (sec || wb_dat_i[CMD_SECURE] && !prog);
         prog <= wb_dat_i[CMD_PROG_START] ||
            prog && !wb_dat_i[CMD_PROG_END];
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tst <= 1'b0;
         pre <= PRELOAD_RESET;
      end else if (wrt && wb_adr_i == OFS_CTRL) begin
         tst <= wb_dat_i[CTRL_TEST];
      end else if (wrt && wb_adr_i == OFS_PRELOAD) begin
         pre <= wb_dat_i[MC_COUNT-1:0];
      end
   end
   property p_reset;
      $fell(rst_i) |-> mc_q_o == '0 && io_pin_oe_n_o == '1;
   endproperty
   a_reset: assert property (p_reset)
      else $error("outputs not cleared by reset");
   property p_por;
      rd && wb_adr_i == OFS_STATUS && por > 8'h65 |-> wb_dat_o[ST_POR_DONE];
   endproperty
   a_por: assert property (p_por)
      else $error("power-up reset too slow");
   property p_pol;
      $changed(mc_q_o) && $stable(io_pin_oe_n_o) |=>
         (io_pin_o ^ $past(io_pin_o)) == ($past(mc_q_o) ^ $past(mc_q_o, 2));
   endproperty
   a_pol: assert property (p_pol)
      else $error("pin does not follow register");
   property p_float;
      (in_float_i & $past(in_float_i) & $past(in_float_i, 2)
         & $past(in_float_i, 3) & ~pin_level_o[IN_COUNT-1:0]) == '0;
   endproperty
   a_float: assert property (p_float)
      else $error("floating input not high");
   property p_preload;
      cmd && wb_dat_i[CMD_PRELOAD] && tst |-> ##[0:1] mc_q_o == pre;
   endproperty
   a_preload: assert property (p_preload)
      else $error("preload value not loaded");
   property p_step;
      cmd && wb_dat_i[CMD_STEP] && !wb_dat_i[CMD_PRELOAD] && tst
         |-> ##[0:1] mc_q_o == mc_d_i;
   endproperty
   a_step: assert property (p_step)
      else $error("step did not load next state");
   property p_refuse;
      cmd && wb_dat_i[CMD_PRELOAD] && !tst && !mc_clk_i
         |-> $stable(mc_q_o) ##1 $stable(mc_q_o);
   endproperty
   a_refuse: assert property (p_refuse)
      else $error("preload acted outside test mode");
   property p_rdsec;
      rd && wb_adr_i == OFS_RD_DATA && sec |-> wb_dat_o == '0;
   endproperty
   a_rdsec: assert property (p_rdsec)
      else $error("secured pattern was read back");
   c_preload: cover property (cmd && wb_dat_i[CMD_PRELOAD] && tst);
   c_step: cover property (cmd && wb_dat_i[CMD_STEP] && tst);
   c_rdsec: cover property (rd && wb_adr_i == OFS_RD_DATA && sec);
endmodule
bind pld_register_init_and_config_guard pld_guard_sva pld_guard_sva_inst (
   .clk_i(clk_i), .rst_i(rst_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .mc_clk_i(mc_clk_i), .in_float_i(in_float_i), .mc_d_i(mc_d_i),
   .io_pin_o(io_pin_o), .io_pin_oe_n_o(io_pin_oe_n_o), .mc_q_o(mc_q_o),
   .pin_level_o(pin_level_o));
`default_nettype wire

// file: sim/sys_side.sv
// partner model: pin wires and macrocell clock source
`timescale 1ns/10ps
`default_nettype none
module sys_side
   import pld_pkg::*;
(
   input wire logic clk_i,
   input wire logic [MC_COUNT-1:0] io_val_i,
   input wire logic [MC_COUNT-1:0] io_flt_i,
   input wire logic [MC_COUNT-1:0] dev_io_i,
   input wire logic [MC_COUNT-1:0] dev_oe_n_i,
   output logic [MC_COUNT-1:0] io_pin_o,
   output logic [MC_COUNT-1:0] io_float_o,
   output logic mc_clk_o
);
   // undriven lines carry junk, only the float flags mark them
   assign io_pin_o = (~dev_oe_n_i & dev_io_i) |
      (dev_oe_n_i & (io_val_i ^ io_flt_i));
   assign io_float_o = dev_oe_n_i & io_flt_i;
   initial begin
      mc_clk_o = 1'b0;
   end
   task automatic pulse();
      @(posedge clk_i);
      mc_clk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      mc_clk_o <= 1'b0;
      repeat (4) @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// testbench: register-level scenarios for the config guard
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import pld_pkg::*;
   localparam logic [9:0] POL = 10'h155;
   localparam logic [9:0] OEN = 10'h30F;
   logic clk, rst, cyc, stb, we, ack, mc_clk;
   logic [7:0] adr;
   logic [31:0] dat, rdat;
   logic [9:0] mc_d, io_val, io_flt, io_o, oe_n, mc_q, io_pin, io_fl;
   logic [11:0] in_val, in_flt, in_pin;
   logic [21:0] lvl;
   logic [5919:0] img;
   int n_errors = 0;
   int checked = 0;
   assign in_pin = in_val ^ in_flt;
   pld_register_init_and_config_guard pld_register_init_and_config_guard_inst (
      .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .mc_clk_i(mc_clk), .in_pin_i(in_pin),
      .in_float_i(in_flt), .io_pin_i(io_pin), .io_float_i(io_fl),
      .mc_d_i(mc_d), .io_pin_o(io_o), .io_pin_oe_n_o(oe_n), .mc_q_o(mc_q),
      .pin_level_o(lvl));
   sys_side sys_side_inst (.clk_i(clk), .io_val_i(io_val), .io_flt_i(io_flt),
      .dev_io_i(io_o), .dev_oe_n_i(oe_n), .io_pin_o(io_pin),
      .io_float_o(io_fl), .mc_clk_o(mc_clk));
   task automatic print_verdict();
      $display("mismatches %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] s);
      checked++;
      if (s !== e) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 400);
      q = rdat;
      if (n >= 400) begin
         chk("bus ack", 32'h1, 32'h0);
      end
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask
   task automatic rc(input string nm, input logic [7:0] a,
      input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      chk(nm, e, q);
   endtask
   task automatic wst(input int b, input logic v);
      logic [31:0] q;
      int n;
      n = 0;
      do begin
         wb(1'b0, OFS_STATUS, 32'h0, q);
         n++;
      end while (q[b] !== v && n < 300);
      chk("status wait", {31'h0, v}, {31'h0, q[b]});
   endtask
   task automatic settle();
      repeat (2) @(negedge clk);
   endtask
   task automatic prog(input logic std);
      wr(OFS_CTRL, {30'h0, std, 1'b0});
      wr(OFS_CMD, 32'h1);
      wst(ST_BUSY, 1'b0);
      rc("status erase", OFS_STATUS, std ? 32'h4C : 32'hC);
      rc("word erase", OFS_RD_DATA, 32'h0);
      for (int i = 0; i < (std ? 183 : 185); i++) begin
         wr(OFS_PROG_DATA, img[i*32 +: 32]);
      end
      wr(OFS_CMD, 32'h2);
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #200000;
      n_errors++;
      print_verdict();
   end
   initial begin
      rst = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      dat = 32'h0;
      mc_d = 10'h0F0;
      in_val = 12'h123;
      in_flt = 12'h000;
      io_val = 10'h0;
      io_flt = 10'h0;
      for (int i = 0; i < 185; i++) begin
         img[i*32 +: 32] = 32'(32'h9E3779B9 * (i + 1));
      end
      img[31:0] = {12'h0, ~OEN, POL};
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      wst(ST_POR_DONE, 1'b1);
      rc("status por", OFS_STATUS, 32'h8);
      wr(8'h3C, 32'hFFFFFFFF);
      rc("unmapped", 8'h3C, 32'h0);
      prog(1'b0);
      rc("sig lo", OFS_SIG_LO, img[5859:5828]);
      rc("sig hi", OFS_SIG_HI, img[5891:5860]);
      settle();
      chk("oe_n", {22'h0, OEN}, {22'h0, oe_n});
      chk("pin out", {22'h0, POL}, {22'h0, io_o});
      wr(OFS_RD_ADDR, 32'h5);
      rc("readback", OFS_RD_DATA, img[191:160]);
      rc("rd addr", OFS_RD_ADDR, 32'h5);
      wr(OFS_CMD, 32'h4);
      rc("status sec", OFS_STATUS, 32'h9);
      rc("readback sec", OFS_RD_DATA, 32'h0);
      rc("status refused", OFS_STATUS, 32'h19);
      rc("sig lo sec", OFS_SIG_LO, img[5859:5828]);
      rc("sig hi sec", OFS_SIG_HI, img[5891:5860]);
      wr(OFS_STATUS, 32'h10);
      prog(1'b1);
      rc("sig std lo", OFS_SIG_LO, 32'h0);
      rc("sig std hi", OFS_SIG_HI, 32'h0);
      rc("readback new", OFS_RD_DATA, img[191:160]);
      wr(OFS_PRELOAD, 32'h2AA);
      rc("preload reg", OFS_PRELOAD, 32'h2AA);
      wr(OFS_CMD, 32'h8);
      rc("status pl", OFS_STATUS, 32'h68);
      settle();
      chk("mc refused", 32'h0, {22'h0, mc_q});
      wr(OFS_STATUS, 32'h20);
      rc("status pl clr", OFS_STATUS, 32'h48);
      wr(OFS_CTRL, 32'h3);
      wr(OFS_CMD, 32'h8);
      settle();
      chk("mc preload", 32'h2AA, {22'h0, mc_q});
      chk("pin preload", {22'h0, 10'h2AA ^ POL}, {22'h0, io_o});
      wr(OFS_CMD, 32'h10);
      mc_d <= 10'h3C3;
      settle();
      chk("mc step", 32'h0F0, {22'h0, mc_q});
      sys_side_inst.pulse();
      settle();
      chk("mc hold", 32'h0F0, {22'h0, mc_q});
      wr(OFS_CTRL, 32'h2);
      sys_side_inst.pulse();
      settle();
      chk("mc clocked", 32'h3C3, {22'h0, mc_q});
      rc("mc state", OFS_MC_STATE, 32'h3C3);
      in_flt <= 12'hA5A;
      io_flt <= 10'h3FF;
      repeat (6) @(posedge clk);
      settle();
      chk("pins", {10'h0, OEN | (~OEN & (10'h3C3 ^ POL)),
         12'hA5A | 12'h123}, {10'h0, lvl});
      rc("pins reg", OFS_PINS, {10'h0, OEN | (~OEN & (10'h3C3 ^ POL)),
         12'hA5A | 12'h123});
      print_verdict();
   end
endmodule
`default_nettype wire
